/* design/pll_divider_serial_control.sv */
`timescale 1ns/1ps
module pll_divider_serial_control
  import pll_ctrl_pkg::*;
#(
  parameter int NW = NDIV_W,
  parameter int RW = RDIV_W
) (
  input  wire logic          clk_sys,
  input  wire logic          nrst,
  input  wire logic          chip_enable,
  input  wire logic          serial_clock,
  input  wire logic          serial_data,
  input  wire logic          load_strobe,
  input  wire logic          reference_input,
  input  wire logic          feedback_input,
  input  wire logic          feedback_input_complement,
  output logic               observation_output,
  output logic               pump_output,
  output logic               pump_output_oe_n,
  output logic               powered_down,
  output logic               ref_bias_switch_a,
  output logic               ref_bias_switch_b,
  output logic               ref_park_switch,
  output logic               pfd_ref_clock,
  output logic               pfd_fb_clock,
  output logic [SHIFT_W-1:0] ref_latch,
  output logic [SHIFT_W-1:0] fb_latch,
  output logic [SHIFT_W-1:0] func_latch,
  output logic [SHIFT_W-1:0] init_latch
);
  typedef struct packed {
    logic [SHIFT_W-1:0] shift;
    logic               sclk_prev;
    logic               strobe_prev;
    logic               ref_prev;
    logic               fb_prev;
    logic [SHIFT_W-1:0] lat_ref;
    logic [SHIFT_W-1:0] lat_fb;
    logic [SHIFT_W-1:0] lat_func;
    logic [SHIFT_W-1:0] lat_init;
    logic               pd;
    logic               obs;
  } ctrl_state_t;
  ctrl_state_t s_q;
  ctrl_state_t s_d;

  logic ref_tick;
  logic fb_tick;
  logic locked;
  logic run;

  div_if #(.W(RW)) ref_bus ();
  div_if #(.W(NW)) fb_bus ();

  function automatic logic rise(input logic prev, input logic now);
    rise = now && !prev;
  endfunction

  assign ref_tick = rise(s_q.ref_prev, reference_input);
  // differential feedback: count only valid complementary rise
  assign fb_tick  = rise(s_q.fb_prev, feedback_input) && !feedback_input_complement;
  assign run      = !s_q.pd;

  assign ref_bus.ratio = s_q.lat_ref[RDIV_LSB +: RW];
  assign ref_bus.run   = run;
  assign ref_bus.tick  = ref_tick;
  assign fb_bus.ratio  = s_q.lat_fb[NDIV_LSB +: NW];
  assign fb_bus.run    = run;
  assign fb_bus.tick   = fb_tick;

  prog_divider #(.W(RW)) u_ref_div (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .bus     (ref_bus)
  );

  prog_divider #(.W(NW)) u_fb_div (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .bus     (fb_bus)
  );

  lock_detector u_lock (
    .clk_sys   (clk_sys),
    .nrst      (nrst),
    .enable    (run),
    .precise   (s_q.lat_ref[LOCK_PREC_POS]),
    .ref_pulse (ref_bus.out_div),
    .fb_pulse  (fb_bus.out_div),
    .locked    (locked)
  );

  always_comb begin
    s_d           = s_q;
    s_d.sclk_prev = serial_clock;
    s_d.strobe_prev = load_strobe;
    s_d.ref_prev  = reference_input;
    s_d.fb_prev   = feedback_input;
    if (rise(s_q.sclk_prev, serial_clock)) begin
      s_d.shift = {s_q.shift[SHIFT_W-2:0], serial_data};
    end
    if (rise(s_q.strobe_prev, load_strobe)) begin
      if (s_q.shift[1:0] == SEL_REF_LATCH) begin
        s_d.lat_ref = s_q.shift;
      end else if (s_q.shift[1:0] == SEL_FB_LATCH) begin
        s_d.lat_fb = s_q.shift;
      end else if (s_q.shift[1:0] == SEL_FUNC_LATCH) begin
        s_d.lat_func = s_q.shift;
      end else begin
        s_d.lat_init = s_q.shift;
      end
    end
    // power down: pin low, or select bit clear
    s_d.pd = !chip_enable || !s_q.lat_func[PD_SEL_POS];
    case (s_q.lat_func[OBS_LSB +: OBS_W])
      OBS_LOCK:    s_d.obs = locked;
      OBS_FB_DIV:  s_d.obs = fb_bus.out_div;
      OBS_HIGH:    s_d.obs = 1'b1;
      OBS_REF_DIV: s_d.obs = ref_bus.out_div;
      default:     s_d.obs = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      s_q          <= '0;
      s_q.pd       <= 1'b1;
      s_q.lat_ref  <= LATCH_RESET;
      s_q.lat_fb   <= LATCH_RESET;
      s_q.lat_func <= LATCH_RESET;
      s_q.lat_init <= LATCH_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign observation_output = s_q.obs;
  assign powered_down       = s_q.pd;
  assign pump_output        = 1'b0;
  assign pump_output_oe_n   = s_q.pd || s_q.lat_func[PUMP_TRI_POS];
  assign ref_bias_switch_a  = !s_q.pd;
  assign ref_bias_switch_b  = !s_q.pd;
  assign ref_park_switch    = s_q.pd;
  assign pfd_ref_clock      = ref_bus.out_div;
  assign pfd_fb_clock       = fb_bus.out_div;
  assign ref_latch          = s_q.lat_ref;
  assign fb_latch           = s_q.lat_fb;
  assign func_latch         = s_q.lat_func;
  assign init_latch         = s_q.lat_init;
endmodule

/* shared/pll_ctrl_pkg.sv */
package pll_ctrl_pkg;
  localparam int SHIFT_W        = 24;
  localparam int NDIV_W         = 13;
  localparam int RDIV_W         = 14;
  localparam int OBS_W          = 3;
  localparam logic [1:0] SEL_REF_LATCH  = 2'h0;
  localparam logic [1:0] SEL_FB_LATCH   = 2'h1;
  localparam logic [1:0] SEL_FUNC_LATCH = 2'h2;
  localparam logic [1:0] SEL_INIT_LATCH = 2'h3;
  // field positions in the 24-bit word
  localparam int RDIV_LSB       = 2;
  localparam int LOCK_PREC_POS  = 20;
  localparam int NDIV_LSB       = 8;
  localparam int PD_SEL_POS     = 7;
  localparam int OBS_LSB        = 4;
  localparam int PUMP_TRI_POS   = 9;
  // observation select codes
  localparam logic [2:0] OBS_LOW      = 3'h0;
  localparam logic [2:0] OBS_LOCK     = 3'h1;
  localparam logic [2:0] OBS_FB_DIV   = 3'h2;
  localparam logic [2:0] OBS_HIGH     = 3'h3;
  localparam logic [2:0] OBS_REF_DIV  = 3'h4;
  // lock detect timing
  localparam int CLK_PERIOD_PS  = 25000;
  localparam int LOCK_WIN_PS    = 15000;
  localparam int UNLOCK_WIN_PS  = 25000;
  localparam int LOCK_WIN_CYC   = (LOCK_WIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int UNLOCK_WIN_CYC = (UNLOCK_WIN_PS / CLK_PERIOD_PS < 1) ? 1
                                  : UNLOCK_WIN_PS / CLK_PERIOD_PS;
  localparam logic [2:0] LOCK_CNT_NORMAL  = 3'h3;
  localparam logic [2:0] LOCK_CNT_PRECISE = 3'h5;
  localparam logic [SHIFT_W-1:0] LATCH_RESET = 24'h000000;
endpackage

/* shared/div_if.sv */
`timescale 1ns/1ps
interface div_if #(parameter int W = 14);
  logic [W-1:0] ratio;
  logic         run;
  logic         tick;
  logic         out_div;
  modport ctrl (output ratio, output run, output tick, input out_div);
  modport div  (input ratio, input run, input tick, output out_div);
endinterface

/* design/prog_divider.sv */
`timescale 1ns/1ps
module prog_divider #(
  parameter int W = 14
) (
  input wire logic clk_sys,
  input wire logic nrst,
  div_if.div       bus
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         pulse;
  } div_state_t;
  div_state_t s_q;
  div_state_t s_d;
  localparam logic [W-1:0] ONE = {{(W-1){1'b0}}, 1'b1};

  always_comb begin
    s_d = s_q;
    if (!bus.run) begin
      s_d.cnt   = '0;
      s_d.pulse = 1'b0;
    end else if (bus.tick) begin
      // binary count, pulse on terminal count; ratio 0 treated as 1
      if (s_q.cnt + ONE >= bus.ratio) begin
        s_d.cnt   = '0;
        s_d.pulse = 1'b1;
      end else begin
        s_d.cnt   = s_q.cnt + ONE;
        s_d.pulse = 1'b0;
      end
    end else begin
      s_d.pulse = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign bus.out_div = s_q.pulse;
endmodule

/* design/lock_detector.sv */
`timescale 1ns/1ps
module lock_detector
  import pll_ctrl_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic nrst,
  input  wire logic enable,
  input  wire logic precise,
  input  wire logic ref_pulse,
  input  wire logic fb_pulse,
  output wire logic locked
);
  typedef struct packed {
    logic       waiting;
    logic [7:0] gap;
    logic [2:0] good;
    logic       lock;
  } lock_state_t;
  lock_state_t s_q;
  lock_state_t s_d;
  logic [2:0]  need;

  always_comb begin
    s_d  = s_q;
    need = precise ? LOCK_CNT_PRECISE : LOCK_CNT_NORMAL;
    if (!enable) begin
      s_d = '0;
    end else if (ref_pulse && fb_pulse) begin
      s_d.waiting = 1'b0;
      s_d.gap     = '0;
      if (s_q.good + 3'h1 >= need) begin
        s_d.lock = 1'b1;
      end
      if (s_q.good < need) begin
        s_d.good = s_q.good + 3'h1;
      end
    end else if ((ref_pulse || fb_pulse) && !s_q.waiting) begin
      s_d.waiting = 1'b1;
      s_d.gap     = 8'h01;
    end else if ((ref_pulse || fb_pulse) && s_q.waiting) begin
      // phase error measured in cycles between edges
      s_d.waiting = 1'b0;
      s_d.gap     = '0;
      if (32'(s_q.gap) < LOCK_WIN_CYC) begin
        if (s_q.good + 3'h1 >= need) begin
          s_d.lock = 1'b1;
        end
        if (s_q.good < need) begin
          s_d.good = s_q.good + 3'h1;
        end
      end else begin
        s_d.good = '0;
        if (32'(s_q.gap) > UNLOCK_WIN_CYC) begin
          s_d.lock = 1'b0;
        end
      end
    end else if (s_q.waiting && s_q.gap != 8'hFF) begin
      s_d.gap = s_q.gap + 8'h01;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign locked = s_q.lock;
endmodule

/* sim/host_serial.sv */
`timescale 1ns/1ps
module host_serial (
  input  wire logic clk_sys,
  output logic      serial_clock,
  output logic      serial_data,
  output logic      load_strobe
);
  initial begin
    serial_clock = 1'b0;
    serial_data  = 1'b0;
    load_strobe  = 1'b0;
  end
  // one word, serial clock and strobe each held high two clocks
  task automatic send(input logic [23:0] w, input bit ld);
    for (int i = 23; i >= 0; i--) begin
      @(posedge clk_sys) serial_data <= w[i];
      repeat (2) @(posedge clk_sys);
      serial_clock <= 1'b1;
      repeat (2) @(posedge clk_sys);
      serial_clock <= 1'b0;
    end
    @(posedge clk_sys) serial_data <= ~w[0];
    if (ld) begin
      repeat (2) @(posedge clk_sys);
      load_strobe <= 1'b1;
      repeat (2) @(posedge clk_sys);
      load_strobe <= 1'b0;
    end
    repeat (3) @(posedge clk_sys);
  endtask
endmodule

/* sim/pll_ctrl_checker_properties.sv */
`timescale 1ns/1ps
module pll_ctrl_checker
  import pll_ctrl_pkg::*;
(
  input wire logic               clk_sys,
  input wire logic               nrst,
  input wire logic               chip_enable,
  input wire logic               load_strobe,
  input wire logic               observation_output,
  input wire logic               pump_output_oe_n,
  input wire logic               powered_down,
  input wire logic               ref_bias_switch_a,
  input wire logic               ref_park_switch,
  input wire logic               pfd_ref_clock,
  input wire logic [SHIFT_W-1:0] ref_latch,
  input wire logic [SHIFT_W-1:0] fb_latch,
  input wire logic [SHIFT_W-1:0] func_latch
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  property p_ce_low; !chip_enable |=> powered_down; endproperty
  a_ce_low: assert property (p_ce_low) else $error("not down");
  property p_pump; powered_down && $past(powered_down) |-> pump_output_oe_n; endproperty
  a_pump: assert property (p_pump) else $error("pump driven");
  property p_up; chip_enable && func_latch[PD_SEL_POS] |=> !powered_down; endproperty
  a_up: assert property (p_up) else $error("no power up");
  property p_stay; !func_latch[PD_SEL_POS] |=> powered_down; endproperty
  a_stay: assert property (p_stay) else $error("powered up");
  property p_sw; ref_bias_switch_a == !powered_down && ref_park_switch == powered_down; endproperty
  a_sw: assert property (p_sw) else $error("switches");
  property p_hold; !load_strobe |=> $stable(ref_latch) && $stable(fb_latch)
    && $stable(func_latch); endproperty
  a_hold: assert property (p_hold) else $error("latch moved");
  property p_sel; (!$changed(ref_latch) || ref_latch[1:0] == SEL_REF_LATCH)
    && (!$changed(fb_latch) || fb_latch[1:0] == SEL_FB_LATCH)
    && (!$changed(func_latch) || func_latch[1:0] == SEL_FUNC_LATCH); endproperty
  a_sel: assert property (p_sel) else $error("wrong latch");
  property p_obs; (func_latch[OBS_LSB+:OBS_W] == OBS_HIGH)[*3] |-> observation_output;
  endproperty
  a_obs: assert property (p_obs) else $error("obs not high");
  property p_quiet; powered_down[*2] |-> !pfd_ref_clock; endproperty
  a_quiet: assert property (p_quiet) else $error("divider ran");
endmodule
bind pll_divider_serial_control pll_ctrl_checker chk (
  .clk_sys(clk_sys), .nrst(nrst), .chip_enable(chip_enable), .load_strobe(load_strobe),
  .observation_output(observation_output), .pump_output_oe_n(pump_output_oe_n),
  .powered_down(powered_down), .ref_bias_switch_a(ref_bias_switch_a),
  .ref_park_switch(ref_park_switch), .pfd_ref_clock(pfd_ref_clock),
  .ref_latch(ref_latch), .fb_latch(fb_latch), .func_latch(func_latch)
);

/* sim/testbench.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
  $display("Error %s exp %0h got %0h", n, e, g); end end
module testbench;
  import pll_ctrl_pkg::*;
  logic                  clk_sys, nrst, chip_enable, ref_in, fb_in;
  wire logic             sclk, sdat, sload, obs, oe_n, pd, sw_a, sw_b, park, pref, pfb, pump;
  wire logic [3:0][23:0] lat;
  logic [3:0][23:0]      exp_l;
  int                    n_mismatch, checks_done, n_ref, n_fb, n_obs, r0, f0, o0;
  host_serial host (.clk_sys(clk_sys), .serial_clock(sclk), .serial_data(sdat),
    .load_strobe(sload));
  pll_divider_serial_control dut (.clk_sys(clk_sys), .nrst(nrst), .chip_enable(chip_enable),
    .serial_clock(sclk), .serial_data(sdat), .load_strobe(sload), .reference_input(ref_in),
    .feedback_input(fb_in), .feedback_input_complement(~fb_in), .observation_output(obs),
    .pump_output(pump), .pump_output_oe_n(oe_n), .powered_down(pd), .ref_bias_switch_a(sw_a),
    .ref_bias_switch_b(sw_b), .ref_park_switch(park), .pfd_ref_clock(pref),
    .pfd_fb_clock(pfb), .ref_latch(lat[0]), .fb_latch(lat[1]), .func_latch(lat[2]),
    .init_latch(lat[3]));
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    n_ref <= n_ref + pref;
    n_fb  <= n_fb + pfb;
    n_obs <= n_obs + obs;
  end
  task report_and_stop;
    if (n_mismatch == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // write one word, track expected latch
  task wr(input logic [23:0] v, input bit ld);
    host.send(v, ld);
    if (ld) exp_l[v[1:0]] = v;
    #1;
  endtask
  task chk_latches;
    for (int k = 0; k < 4; k++) `CHK("latch", exp_l[k], lat[k])
  endtask
  // n reference and feedback rises, then settle
  task tick_run(input int n);
    repeat (n) begin
      @(posedge clk_sys) {ref_in, fb_in} <= 2'h3;
      repeat (2) @(posedge clk_sys);
      {ref_in, fb_in} <= 2'h0;
      @(posedge clk_sys);
    end
    repeat (6) @(posedge clk_sys) #1;
  endtask
  initial begin
    repeat (100000) @(posedge clk_sys);
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    {nrst, chip_enable, ref_in, fb_in} = 4'h0;
    {n_mismatch, checks_done, n_ref, n_fb, n_obs} = '0;
    exp_l = '0;
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys) #1;
    chk_latches();
    `CHK("pd", 1'b1, pd)
    for (int s = 0; s < 4; s++) begin
      wr({22'h2A5B3C + 22'(s), 2'(s)}, 1'b1);
      chk_latches();
    end
    wr(24'hFFFFFF, 1'b0);
    chk_latches();
    wr(24'h0000B2, 1'b1);
    `CHK("pd", 1'b1, pd)
    `CHK("park", 1'b1, park)
    @(posedge clk_sys) chip_enable <= 1'b1;
    repeat (3) @(posedge clk_sys) #1;
    `CHK("pd", 1'b0, pd)
    `CHK("sw_b", 1'b1, sw_b)
    `CHK("oe_n", 1'b0, oe_n)
    `CHK("obs", 1'b1, obs)
    wr(24'h000002, 1'b1);
    `CHK("pd", 1'b1, pd)
    `CHK("obs", 1'b0, obs)
    wr(24'h10000C, 1'b1);
    wr(24'h000101, 1'b1);
    wr(24'h0000C2, 1'b1);
    {r0, f0, o0} = {n_ref, n_fb, n_obs};
    tick_run(30);
    `CHK("n_ref", 10, n_ref - r0)
    `CHK("n_fb", 30, n_fb - f0)
    `CHK("n_obs", 10, n_obs - o0)
    wr(24'h000301, 1'b1);
    wr(24'h000092, 1'b1);
    `CHK("lock", 1'b0, obs)
    tick_run(6);
    `CHK("lock", 1'b0, obs)
    tick_run(12);
    `CHK("lock", 1'b1, obs)
    wr(24'h000101, 1'b1);
    tick_run(6);
    `CHK("lock", 1'b0, obs)
    wr(24'h0002A2, 1'b1);
    `CHK("oe_n", 1'b1, oe_n)
    `CHK("pd", 1'b0, pd)
    o0 = n_obs;
    tick_run(6);
    `CHK("n_obs", 6, n_obs - o0)
    @(posedge clk_sys) chip_enable <= 1'b0;
    repeat (3) @(posedge clk_sys) #1;
    `CHK("pd", 1'b1, pd)
    `CHK("pump", 1'b0, pump)
    `CHK("oe_n", 1'b1, oe_n)
    `CHK("sw_a", 1'b0, sw_a)
    report_and_stop();
  end
endmodule
